// [rtl/tvbm_master.sv]
// test vector bus master: tester handshake to single-word bus transfers
// Contract
// - Each write or read vector the tester applies becomes a transfer this block issues as bus master; an address vector only loads the address.
// - The two request inputs together select the type of the vector being applied.
// - The acknowledge output tells the tester when the next vector may be applied.
// - Test-vector mode is entered only while the test-mode input is asserted.
// - Vector data travels over a 32-bit external data path.
// - Test mode is entered when reset is released with the test-mode input held.
// - After entering test mode the block requests the bus from the arbiter.
// - Once granted the block owns the bus and drives transfers on it.
`timescale 1ns/1ps
`default_nettype none
module tvbm_master #(
  parameter int unsigned DATA_W = tvbm_pkg::DATA_W,
  parameter int unsigned ADDR_W = tvbm_pkg::ADDR_W
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              test_mode_entry_in,
  input  wire logic              vector_type_req_a_in,
  input  wire logic              vector_type_req_b_in,
  input  wire logic [DATA_W-1:0] vector_data_in,
  output logic      [DATA_W-1:0] vector_data_out,
  output logic                   vector_data_oe_out,
  output logic                   vector_accept_ack_out,
  output logic                   test_mode_active_out,
  output logic                   test_master_bus_request_out,
  input  wire logic              test_master_bus_grant_in,
  input  wire logic              bus_ready_in,
  input  wire logic [1:0]        bus_resp_in,
  input  wire logic [DATA_W-1:0] bus_rdata_in,
  output logic      [ADDR_W-1:0] bus_addr_out,
  output logic      [1:0]        bus_trans_out,
  output logic                   bus_write_out,
  output logic      [2:0]        bus_size_out,
  output logic      [2:0]        bus_burst_out,
  output logic      [DATA_W-1:0] bus_wdata_out
);
  initial begin
    if (DATA_W != 32) begin
      $error("tvbm_master: vector data path must be 32 bits"); 
    end
    if (ADDR_W < 2 || ADDR_W > 32) begin
      $error("tvbm_master: ADDR_W must be 2 to 32");
    end
  end

  // pin inputs pass two flops first
  logic              s_mode;
  logic [1:0]        s_req;
  logic [DATA_W-1:0] s_data;
  tvbm_sync #(.WIDTH(DATA_W + 3)) u_sync (
    .clk_in   (clk_in),
    .async_in ({test_mode_entry_in, vector_type_req_b_in, vector_type_req_a_in,
                vector_data_in}),
    .sync_out ({s_mode, s_req, s_data})
  );

  tvbm_pkg::tvbm_state_e state;
  tvbm_pkg::tvbm_state_e next_state;
  logic              mode;
  logic              next_mode;
  logic              armed;
  logic              next_armed;
  logic [1:0]        last_req;
  logic [1:0]        next_last_req;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] next_wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic              wr;
  logic              next_wr;
  logic              req;
  logic              next_req;
  logic [1:0]        trans;
  logic [1:0]        next_trans;
  logic              ack;
  logic              next_ack;
  logic              oe;
  logic              next_oe;

  // a new vector is a change of code away from idle
  function automatic logic is_new(input logic [1:0] cur, input logic [1:0] prev);
    is_new = (cur != tvbm_pkg::VEC_IDLE) && (cur != prev);
  endfunction

  always_comb begin
    next_state    = state;
    next_mode     = mode;
    next_armed    = 1'b0;
    next_last_req = s_req;
    next_addr     = addr;
    next_wdata    = wdata;
    next_rdata    = rdata;
    next_wr       = wr;
    next_req      = req;
    next_trans    = tvbm_pkg::TRANS_IDLE;
    next_ack      = 1'b0;
    next_oe       = oe;
    case (state)
      tvbm_pkg::TVBM_OFF: begin
        // mode latched only on the first cycle after reset release
        next_armed = 1'b0;
        if (armed && s_mode) begin
          next_mode  = 1'b1;
          next_req   = 1'b1;
          next_state = tvbm_pkg::TVBM_REQ;
        end
      end
      tvbm_pkg::TVBM_REQ: begin
        // wait for ownership; slow clock makes the extra cycle harmless
        if (test_master_bus_grant_in && bus_ready_in) begin
          next_state = tvbm_pkg::TVBM_IDLE;
        end
      end
      tvbm_pkg::TVBM_IDLE: begin
        if (!s_mode) begin
          next_mode  = 1'b0;
          next_req   = 1'b0;
          next_oe    = 1'b0;
          next_state = tvbm_pkg::TVBM_OFF;
        end else if (is_new(s_req, last_req)) begin
          case (s_req)
            tvbm_pkg::VEC_ADDR: begin
              next_addr = s_data[ADDR_W-1:0];
              next_oe   = 1'b0;
              next_ack  = 1'b1;
            end
            tvbm_pkg::VEC_WDATA: begin
              next_wdata = s_data;
              next_wr    = 1'b1;
              next_oe    = 1'b0;
              next_state = tvbm_pkg::TVBM_ADDR_PH;
            end
            tvbm_pkg::VEC_RDATA: begin
              next_wr    = 1'b0;
              next_state = tvbm_pkg::TVBM_ADDR_PH;
            end
            default: begin
              next_state = tvbm_pkg::TVBM_IDLE;
            end
          endcase
        end
      end
      tvbm_pkg::TVBM_ADDR_PH: begin
        if (test_master_bus_grant_in && bus_ready_in) begin
          next_trans = tvbm_pkg::TRANS_NONSEQ;
          next_state = tvbm_pkg::TVBM_DATA_PH;
        end
      end
      tvbm_pkg::TVBM_DATA_PH: begin
        // one cycle after issue the address phase is over
        if (bus_ready_in && trans == tvbm_pkg::TRANS_IDLE) begin
          if (!wr) begin
            next_rdata = bus_rdata_in;
            next_oe    = 1'b1;
          end
          // sequential vectors walk words
          next_addr  = ADDR_W'(addr + ADDR_W'(tvbm_pkg::WORD_STEP));
          next_state = tvbm_pkg::TVBM_ACK;
        end
      end
      tvbm_pkg::TVBM_ACK: begin
        next_ack   = 1'b1;
        next_state = tvbm_pkg::TVBM_IDLE;
      end
      default: begin
        next_state = tvbm_pkg::TVBM_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state    <= tvbm_pkg::TVBM_OFF;
      mode     <= 1'b0;
      armed    <= 1'b1;
      last_req <= tvbm_pkg::VEC_IDLE;
      addr     <= tvbm_pkg::ADDR_RESET[ADDR_W-1:0];
      wdata    <= tvbm_pkg::DATA_RESET;
      rdata    <= tvbm_pkg::DATA_RESET;
      wr       <= 1'b0;
      req      <= 1'b0;
      trans    <= tvbm_pkg::TRANS_IDLE;
      ack      <= 1'b0;
      oe       <= 1'b0;
    end else begin
      state    <= next_state;
      mode     <= next_mode;
      armed    <= next_armed;
      last_req <= next_last_req;
      addr     <= next_addr;
      wdata    <= next_wdata;
      rdata    <= next_rdata;
      wr       <= next_wr;
      req      <= next_req;
      trans    <= next_trans;
      ack      <= next_ack;
      oe       <= next_oe;
    end
  end

  assign vector_data_out             = rdata;
  assign vector_data_oe_out          = oe;
  assign vector_accept_ack_out       = ack;
  assign test_mode_active_out        = mode;
  assign test_master_bus_request_out = req;
  assign bus_addr_out                = addr;
  assign bus_trans_out               = trans;
  assign bus_write_out               = wr;
  assign bus_size_out                = tvbm_pkg::SIZE_WORD;
  assign bus_burst_out               = tvbm_pkg::BURST_SINGLE;
  assign bus_wdata_out               = wdata;
endmodule
`default_nettype wire

// [rtl/tvbm_pkg.sv]
// package: constants and types of the test vector bus master
package tvbm_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  // vector type codes on {req_b, req_a}
  localparam logic [1:0] VEC_IDLE  = 2'h0;
  localparam logic [1:0] VEC_ADDR  = 2'h1;
  localparam logic [1:0] VEC_WDATA = 2'h2;
  localparam logic [1:0] VEC_RDATA = 2'h3;
  // bus transfer encodings (published bus values)
  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SIZE_WORD    = 3'h2;
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
  // bytes the address advances after each data vector
  localparam int unsigned WORD_STEP   = 4;
  typedef enum logic [2:0] {
    TVBM_OFF,
    TVBM_REQ,
    TVBM_IDLE,
    TVBM_ADDR_PH,
    TVBM_DATA_PH,
    TVBM_ACK
  } tvbm_state_e;
endpackage

// [rtl/tvbm_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tvbm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;
  initial begin
    if (WIDTH < 1) begin
      $error("tvbm_sync: WIDTH must be at least 1");
    end
  end
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end
  // no reset: the pin level must already be through both flops on the
  // first cycle after release, or test-mode entry is never seen
  always_ff @(posedge clk_in) begin
    meta     <= next_meta;
    sync_out <= next_sync;
  end
endmodule
`default_nettype wire

// [tb/tvbm_asserts.sv]
// checker: port-level timing of the test vector bus master
`timescale 1ns/1ps
`default_nettype none
module tvbm_asserts (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        vector_accept_ack_out,
  input wire logic        test_mode_active_out,
  input wire logic        test_master_bus_request_out,
  input wire logic [31:0] bus_addr_out,
  input wire logic [1:0]  bus_trans_out,
  input wire logic [2:0]  bus_size_out,
  input wire logic [2:0]  bus_burst_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_ack_pulse; vector_accept_ack_out |=> !vector_accept_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
  property p_rst; $rose(nrst_in) |-> !test_master_bus_request_out && !vector_accept_ack_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active out of reset");
  property p_ns; bus_trans_out == tvbm_pkg::TRANS_NONSEQ |=> bus_trans_out == 2'h0; endproperty
  a_ns: assert property (p_ns) else $error("transfer not single");
  // a change without ack is the post-transfer step; an address vector comes with ack
  property p_inc; $changed(bus_addr_out) && !vector_accept_ack_out
    |-> bus_addr_out == $past(bus_addr_out) + 32'h4; endproperty
  a_inc: assert property (p_inc) else $error("address not advanced by 4");
  property p_ack; bus_trans_out == tvbm_pkg::TRANS_NONSEQ |-> ##[2:40] vector_accept_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after transfer");
  property p_mode; test_master_bus_request_out |-> test_mode_active_out; endproperty
  a_mode: assert property (p_mode) else $error("request outside test mode");
  property p_word; bus_size_out == 3'h2 && bus_burst_out == 3'h0; endproperty
  a_word: assert property (p_word) else $error("transfer not single word");
  property p_req; $rose(test_mode_active_out) |-> ##[0:2] test_master_bus_request_out;
  endproperty
  a_req: assert property (p_req) else $error("no bus request in test mode");
endmodule
bind tvbm_master tvbm_asserts i_chk (
  .clk_in                      (clk_in),
  .nrst_in                     (nrst_in),
  .vector_accept_ack_out       (vector_accept_ack_out),
  .test_mode_active_out        (test_mode_active_out),
  .test_master_bus_request_out (test_master_bus_request_out),
  .bus_addr_out                (bus_addr_out),
  .bus_trans_out               (bus_trans_out),
  .bus_size_out                (bus_size_out),
  .bus_burst_out               (bus_burst_out)
);
`default_nettype wire

// [tb/tvbm_bus_partner.sv]
// bus partner: arbiter plus word memory with programmable wait states
`timescale 1ns/1ps
`default_nettype none
module tvbm_bus_partner (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        request_in,
  input  wire logic [1:0]  trans_in,
  input  wire logic [31:0] addr_in,
  input  wire logic        write_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [1:0]  waits_in,
  output logic             grant_out,
  output logic             ready_out,
  output logic      [31:0] rdata_out
);
  // word index from address bits 9:2; tests stay inside that window
  logic [31:0] mem [0:255];
  logic [31:0] a;
  logic        dph;
  logic        wr;
  logic [1:0]  cnt;
  // stands for the bus shared with the processor and the register port
  always @(posedge clk_in) begin
    // never default master: grant only follows a request
    grant_out <= nrst_in && request_in;
    if (!nrst_in) begin
      dph <= 1'b0;
      ready_out <= 1'b1;
      rdata_out <= 32'h0;
    end else if (dph && ready_out) begin
      if (wr) mem[a[9:2]] <= wdata_in;
      dph <= 1'b0;
      rdata_out <= ~rdata_out;
    end else if (dph) begin
      cnt <= cnt - 2'h1;
      ready_out <= (cnt == 2'h1);
      rdata_out <= (cnt == 2'h1) ? mem[a[9:2]] : ~rdata_out;
    end else if (trans_in == 2'h2 && ready_out && grant_out) begin
      dph <= 1'b1;
      a <= addr_in;
      wr <= write_in;
      cnt <= waits_in;
      ready_out <= (waits_in == 2'h0);
      rdata_out <= (waits_in == 2'h0) ? mem[addr_in[9:2]] : ~rdata_out;
    end else rdata_out <= ~rdata_out;
  end
endmodule
`default_nettype wire

// [tb/test_tvbm_master.sv]
// testbench: tester handshake through bus transfers
`timescale 1ns/1ps
`default_nettype none
module test_tvbm_master;
  logic clk_in = 0, nrst_in = 0, test_mode_entry_in = 0, got;
  logic vector_type_req_a_in = 0, vector_type_req_b_in = 0;
  logic [31:0] vector_data_in = 32'h0, bus_rdata_in, vector_data_out, bus_addr_out, bus_wdata_out;
  logic [1:0]  bus_resp_in = 2'h0, waits = 2'h1, bus_trans_out;
  logic test_master_bus_grant_in, bus_ready_in, vector_data_oe_out, vector_accept_ack_out;
  logic test_mode_active_out, test_master_bus_request_out, bus_write_out;
  logic [2:0]  bus_size_out, bus_burst_out;
  int failures = 0, total_checks = 0;
  always #2 clk_in = ~clk_in;
  tvbm_master i_dut (
    .clk_in                      (clk_in),
    .nrst_in                     (nrst_in),
    .test_mode_entry_in          (test_mode_entry_in),
    .vector_type_req_a_in        (vector_type_req_a_in),
    .vector_type_req_b_in        (vector_type_req_b_in),
    .vector_data_in              (vector_data_in),
    .vector_data_out             (vector_data_out),
    .vector_data_oe_out          (vector_data_oe_out),
    .vector_accept_ack_out       (vector_accept_ack_out),
    .test_mode_active_out        (test_mode_active_out),
    .test_master_bus_request_out (test_master_bus_request_out),
    .test_master_bus_grant_in    (test_master_bus_grant_in),
    .bus_ready_in                (bus_ready_in),
    .bus_resp_in                 (bus_resp_in),
    .bus_rdata_in                (bus_rdata_in),
    .bus_addr_out                (bus_addr_out),
    .bus_trans_out               (bus_trans_out),
    .bus_write_out               (bus_write_out),
    .bus_size_out                (bus_size_out),
    .bus_burst_out               (bus_burst_out),
    .bus_wdata_out               (bus_wdata_out)
  );
  tvbm_bus_partner i_bus (.clk_in(clk_in), .nrst_in(nrst_in),
    .request_in(test_master_bus_request_out), .trans_in(bus_trans_out), .addr_in(bus_addr_out),
    .write_in(bus_write_out), .wdata_in(bus_wdata_out), .waits_in(waits),
    .grant_out(test_master_bus_grant_in), .ready_out(bus_ready_in), .rdata_out(bus_rdata_in));
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic start(input logic mode);
    nrst_in = 0;
    test_mode_entry_in = mode;
    repeat (2) @(negedge clk_in);
    nrst_in = 1;
    repeat (6) @(negedge clk_in);
  endtask
  // code 0 restored after each vector so identical codes stay distinct
  task automatic vec(input logic [1:0] c, input logic [31:0] d, input logic e);
    got = 0;
    {vector_type_req_b_in, vector_type_req_a_in} = c;
    vector_data_in = d;
    for (int i = 0; i < 60 && !got; i++) begin
      @(posedge clk_in);
      #1 got = vector_accept_ack_out;
    end
    chk({31'h0, got}, {31'h0, e}, "ack");
    if (e && !got) final_report();
    @(negedge clk_in);
    {vector_type_req_b_in, vector_type_req_a_in} = 2'h0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic t_no_mode;
    start(1'b0);
    chk({31'h0, test_mode_active_out}, 32'h0, "mode");
    vec(2'h1, 32'h0000_0040, 1'b0);
    $display("test no_mode done");
  endtask
  task automatic t_entry;
    start(1'b1);
    chk({31'h0, test_mode_active_out}, 32'h1, "mode");
    chk({31'h0, test_master_bus_request_out}, 32'h1, "req");
    chk({31'h0, test_master_bus_grant_in}, 32'h1, "grant");
    vec(2'h0, 32'h0, 1'b0);
    $display("test entry done");
  endtask
  task automatic t_write;
    vec(2'h1, 32'h0000_0100, 1'b1);
    vec(2'h2, 32'hA5A5_0001, 1'b1);
    vec(2'h2, 32'h5A5A_FFFE, 1'b1);
    chk(i_bus.mem[8'h40], 32'hA5A5_0001, "wr0");
    chk(i_bus.mem[8'h41], 32'h5A5A_FFFE, "wr1");
    $display("test write done");
  endtask
  task automatic t_read;
    waits = 2'h0;
    vec(2'h1, 32'h0000_0100, 1'b1);
    vec(2'h3, 32'h0, 1'b1);
    chk(vector_data_out, 32'hA5A5_0001, "rd0");
    chk({31'h0, vector_data_oe_out}, 32'h1, "oe");
    waits = 2'h3;
    vec(2'h3, 32'h0, 1'b1);
    chk(vector_data_out, 32'h5A5A_FFFE, "rd1");
    $display("test read done");
  endtask
  task automatic t_leave;
    test_mode_entry_in = 0;
    repeat (8) @(negedge clk_in);
    chk({31'h0, test_master_bus_request_out}, 32'h0, "req");
    chk({31'h0, test_mode_active_out}, 32'h0, "mode");
    $display("test leave done");
  endtask
  initial begin
    t_no_mode();
    t_entry();
    t_write();
    t_read();
    t_leave();
    final_report();
  end
endmodule
`default_nettype wire
